/* hw/pesd_defines.vh */
// Purpose: Constants for the performance event select decoder
// Assumes: Event codes and unit masks are 8 bits wide
// Notes:   Sub-field positions for scope and source masks are a local choice
`ifndef PESD_DEFINES_VH
`define PESD_DEFINES_VH
`define PESD_EV_PAGE_WALK   8'h0C
`define PESD_EV_FP_STACK    8'h10
`define PESD_EV_FP_MICROCODE_HELP   8'h11
`define PESD_EV_MUL         8'h12
`define PESD_EV_DIV         8'h13
`define PESD_EV_DIV_BUSY    8'h14
`define PESD_EV_L2_ADDR     8'h21
`define PESD_EV_L2_DATA     8'h22
`define PESD_EV_L2_FILL     8'h24
`define PESD_EV_L2_WB_IN    8'h25
`define PESD_EV_L2_EVICT    8'h26
`define PESD_EV_L2_DEVICT   8'h27
`define PESD_EV_LEVEL2_CODE_FETCHES   8'h28
`define PESD_UM_PAGE_WALK   8'h03
`define PESD_UM_EXEC        8'h01
`define PESD_UM_RETIRE      8'h81
// Largest increment a summed level-2 event may add in one cycle
`define PESD_INC_SAT        3'h2
// Unit mask fields for level-2 events
`define PESD_UM_BOTH_BIT    7
`define PESD_UM_SRC_DEM_BIT 4
`define PESD_UM_SRC_PF_BIT  5
`define PESD_UM_MESI_LO     0
`define PESD_UM_MESI_HI     3
// Address register offsets
`define PESD_ADDR_CTRL      4'h0
`define PESD_ADDR_STATUS    4'h4
`define PESD_ADDR_COUNT     4'h8
// Control register fields
`define PESD_CTRL_UMASK_LO  8
`define PESD_CTRL_UMASK_HI  15
`define PESD_CTRL_EVENT_LO  0
`define PESD_CTRL_EVENT_HI  7
`define PESD_CTRL_EDGE_BIT  16
`define PESD_CTRL_EN_BIT    17
`define PESD_CTRL_CLR_BIT   18
`define PESD_CTRL_RESET     19'h00000
`endif

/* hw/pesd_decoder.v */
// Purpose: Decode event select and unit mask, produce a counter increment per cycle
// Assumes: Event sources are synchronous to hclk; AHB-Lite single word transfers
// Notes:   Holds one reference counter so software can observe the increment stream
//          Level-2 demand plus prefetch sums saturate at two per cycle
//
// How it works
// - Code 0CH, mask 03H with edge set adds one on each page walk start.
// - Same code and mask with edge clear adds one per cycle while a walk runs.
// - Code 10H counts stack FP compute micro-ops, executed at 01H, retired at 81H.
// - Code 11H with 01H or 81H counts FP operations needing microcode assist.
// - Code 12H counts integer and FP multiplies, executed at 01H, retired at 81H.
// - Code 13H counts divides and square roots, executed at 01H, retired at 81H.
// - Code 14H with mask 01H adds one every cycle the divider is busy.
// - Code 21H adds one each cycle the level-2 address bus carries an access.
// - Code 22H counts data-return cycles, two per full line request.
// - Code 24H counts level-2 fills with demand and prefetch sources selectable.
// - Code 25H adds one per modified line written back from level-1 data cache.
// - Code 26H counts level-2 evictions with demand and prefetch selectable.
// - Code 27H counts modified-line evictions from the level-2 cache.
// - Code 28H counts cacheable code line requests, qualified by line state.
// - For level-2 events the mask chooses local core only or both cores.
`timescale 1ns/1ps
`default_nettype none
`include "pesd_defines.vh"

module pesd_decoder #(
	parameter CNT_W = 32
) (
	input  wire        hclk,
	input  wire        hresetn,
	// Register bus
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Event sources, one bit per event per cycle, same clock
	input  wire        walk_start,
	input  wire        walk_busy,
	input  wire        fp_stack_ops_executed,
	input  wire        fp_stack_ops_retired,
	input  wire        fp_microcode_help,
	input  wire        fp_microcode_help_retired,
	input  wire        multiply_executed,
	input  wire        multiply_retired,
	input  wire        divide_executed,
	input  wire        divide_retired,
	input  wire        divider_busy,
	// Level-2 sources: bit 0 local core, bit 1 other core; level2_code_state is a four-bit line-state vector
	input  wire [1:0]  level2_addr_bus_cycles,
	input  wire [1:0]  level2_data_bus_cycles,
	input  wire [1:0]  level2_fills_demand,
	input  wire [1:0]  level2_fills_prefetch,
	input  wire [1:0]  level2_dirty_writebacks_in,
	input  wire [1:0]  level2_evict_demand,
	input  wire [1:0]  level2_evict_prefetch,
	input  wire [1:0]  level2_dirty_evict_demand,
	input  wire [1:0]  level2_dirty_evict_prefetch,
	input  wire [1:0]  level2_code_fetches,
	input  wire [3:0]  level2_code_state,
	// Counter side
	output wire [1:0]  count_inc,
	output wire [CNT_W-1:0] count_value
);

	reg  [7:0]       event_ff;
	reg  [7:0]       umask_ff;
	reg              edge_ff;
	reg              enable_ff;

	reg  [CNT_W-1:0] count_ff;
	reg  [1:0]       inc_ff;

	reg              wr_pend_ff;
	reg  [3:0]       addr_ff;
	reg  [31:0]      rdata_ff;
	reg  [31:0]      nxt_rdata;
	reg  [1:0]       nxt_inc;
	reg              hit;

	// Count of set bits among the selected cores; local core is bit 0
	function [1:0] scope_sum;
		input [1:0] ev;
		input       both;
		begin
			if (both) begin
				scope_sum = {1'b0, ev[0]} + {1'b0, ev[1]};
			end else begin
				scope_sum = {1'b0, ev[0]};
			end
		end
	endfunction

	// Demand and prefetch selection; both clear means both sources
	function [1:0] src_sum;
		input [1:0] dem;
		input [1:0] pf;
		input [7:0] um;
		reg         sel_d;
		reg         sel_p;
		reg   [1:0] d;
		reg   [1:0] p;
		reg   [2:0] total;
		begin
			sel_d = um[`PESD_UM_SRC_DEM_BIT] | ~um[`PESD_UM_SRC_PF_BIT];
			sel_p = um[`PESD_UM_SRC_PF_BIT] | ~um[`PESD_UM_SRC_DEM_BIT];
			d = sel_d ? scope_sum(dem, um[`PESD_UM_BOTH_BIT]) : 2'h0;
			p = sel_p ? scope_sum(pf, um[`PESD_UM_BOTH_BIT]) : 2'h0;
			// Sum kept three bits wide: two plus two must saturate, not wrap to zero
			total = {1'b0, d} + {1'b0, p};
			if (total > `PESD_INC_SAT)
				total = `PESD_INC_SAT;
			src_sum = total[1:0];
		end
	endfunction

	// Exec or retire source chosen by the mask; any other mask selects nothing
	function pick;
		input [7:0] um;
		input       ex_src;
		input       rt_src;
		begin
			pick = ((um == `PESD_UM_EXEC) & ex_src) | ((um == `PESD_UM_RETIRE) & rt_src);
		end
	endfunction

	// Level-2 mask fields
	wire       l2_both  = umask_ff[`PESD_UM_BOTH_BIT];
	wire [3:0] mesi_sel = umask_ff[`PESD_UM_MESI_HI:`PESD_UM_MESI_LO];
	wire       mesi_ok  = (mesi_sel == 4'h0) | (|(mesi_sel & level2_code_state));
	wire       ex_mask  = (umask_ff == `PESD_UM_EXEC);
	wire       rt_mask  = (umask_ff == `PESD_UM_RETIRE);

	// Bus decode
	wire       take     = hsel & hready & htrans[1];
	wire       ctrl_wr  = wr_pend_ff & (addr_ff == `PESD_ADDR_CTRL);

	// Decode of the selected pair into this cycle's increment
	always @* begin
		nxt_inc = 2'h0;
		hit = 1'b1;
		case (event_ff)
		`PESD_EV_PAGE_WALK: begin
			// Edge set counts walk starts, edge clear counts walk cycles
			if (umask_ff != `PESD_UM_PAGE_WALK)
				hit = 1'b0;
			else if (edge_ff)
				nxt_inc = {1'b0, walk_start};
			else
				nxt_inc = {1'b0, walk_busy};
		end
		`PESD_EV_FP_STACK: begin
			hit = ex_mask | rt_mask;
			nxt_inc = {1'b0, pick(umask_ff, fp_stack_ops_executed,
				fp_stack_ops_retired)};
		end
		`PESD_EV_FP_MICROCODE_HELP: begin
			hit = ex_mask | rt_mask;
			nxt_inc = {1'b0, pick(umask_ff, fp_microcode_help,
				fp_microcode_help_retired)};
		end
		`PESD_EV_MUL: begin
			hit = ex_mask | rt_mask;
			nxt_inc = {1'b0, pick(umask_ff, multiply_executed,
				multiply_retired)};
		end
		`PESD_EV_DIV: begin
			hit = ex_mask | rt_mask;
			nxt_inc = {1'b0, pick(umask_ff, divide_executed,
				divide_retired)};
		end
		`PESD_EV_DIV_BUSY: begin
			// Only the exec mask is defined for the busy-cycle count
			hit = ex_mask;
			nxt_inc = {1'b0, ex_mask & divider_busy};
		end

		// Level-2 events take any mask; the mask only picks scope, source and state
		`PESD_EV_L2_ADDR: begin
			nxt_inc = scope_sum(level2_addr_bus_cycles, l2_both);
		end
		`PESD_EV_L2_DATA: begin
			// Source pulses once per data cycle, so a full line gives two counts
			nxt_inc = scope_sum(level2_data_bus_cycles, l2_both);
		end
		`PESD_EV_L2_FILL: begin
			nxt_inc = src_sum(level2_fills_demand, level2_fills_prefetch,
				umask_ff);
		end
		`PESD_EV_L2_WB_IN: begin
			nxt_inc = scope_sum(level2_dirty_writebacks_in, l2_both);
		end
		`PESD_EV_L2_EVICT: begin
			nxt_inc = src_sum(level2_evict_demand, level2_evict_prefetch,
				umask_ff);
		end
		`PESD_EV_L2_DEVICT: begin
			nxt_inc = src_sum(level2_dirty_evict_demand, level2_dirty_evict_prefetch,
				umask_ff);
		end
		`PESD_EV_LEVEL2_CODE_FETCHES: begin
			// A state filter of zero means any line state
			nxt_inc = mesi_ok ? scope_sum(level2_code_fetches, l2_both)
				: 2'h0;
		end
		default: begin
			hit = 1'b0;
		end
		endcase
		// Enable off or an undefined pair gives no increment
		if (!hit || !enable_ff)
			nxt_inc = 2'h0;
	end

	// Registered increment keeps the counter path one flop away from sources
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			inc_ff <= 2'h0;
		else
			inc_ff <= nxt_inc;
	end

	// Reference count; a clear wins over an increment landing in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count_ff <= {CNT_W{1'b0}};
		else if (ctrl_wr && hwdata[`PESD_CTRL_CLR_BIT])
			count_ff <= {CNT_W{1'b0}};
		else
			count_ff <= count_ff + {{(CNT_W-2){1'b0}}, inc_ff};
	end

	// Address phase captured here; its data phase follows one cycle later
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 4'h0;
		end else begin
			wr_pend_ff <= take & hwrite;
			// Upper address bits are ignored, so the map repeats every sixteen bytes
			if (take)
				addr_ff <= haddr[3:0];
		end
	end

	// Status shows the live decode, so software can see that a pair was refused
	wire [2:0] status_bits = {hit, inc_ff};

	always @* begin
		case (haddr[3:0])
		`PESD_ADDR_CTRL:
			nxt_rdata = {14'h0000, enable_ff, edge_ff, umask_ff, event_ff};
		`PESD_ADDR_STATUS:
			nxt_rdata = {29'h00000000, status_bits};
		// Low word only, should the counter be made wider than the bus
		`PESD_ADDR_COUNT:
			nxt_rdata = count_ff[31:0];
		default:
			nxt_rdata = 32'h00000000;
		endcase
	end

	// Read data is taken in the address phase and stands until the next read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_ff <= 32'h00000000;
		else if (take && !hwrite)
			rdata_ff <= nxt_rdata;
	end

	// The edge bit is plain software state; software clears it to pick walk duration
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_ff <= 8'h00;
			umask_ff <= 8'h00;
			edge_ff <= 1'b0;
			enable_ff <= 1'b0;
		end else if (ctrl_wr) begin
			event_ff <= hwdata[`PESD_CTRL_EVENT_HI:`PESD_CTRL_EVENT_LO];
			umask_ff <= hwdata[`PESD_CTRL_UMASK_HI:`PESD_CTRL_UMASK_LO];
			edge_ff <= hwdata[`PESD_CTRL_EDGE_BIT];
			enable_ff <= hwdata[`PESD_CTRL_EN_BIT];
		end
	end

	// Zero-wait slave: every transfer is answered at once with OKAY
	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign count_inc = inc_ff;
	assign count_value = count_ff;

endmodule

`default_nettype wire

/* verification/pesd_props.sv */
// Purpose: Assertions on the per-cycle increment of the event decoder
// Assumes: Control word is mirrored by snooping bus writes to offset 0
// Notes:   Mirror lands at the edge closing the data phase, like the block's own
`timescale 1ns/1ps
`default_nettype none
module pesd_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        walk_start,
	input wire logic        walk_busy,
	input wire logic        fp_stack_ops_retired,
	input wire logic        multiply_executed,
	input wire logic        divide_retired,
	input wire logic        divider_busy,
	input wire logic [1:0]  level2_addr_bus_cycles,
	input wire logic [1:0]  count_inc
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic        wr_ff;
	logic [17:0] c_ff;
	wire         en = c_ff[17];
	wire  [7:0]  ev = c_ff[7:0];
	wire  [7:0]  um = c_ff[15:8];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			c_ff  <= 18'h00000;
		end else begin
			wr_ff <= hsel && hready && htrans[1] && hwrite && haddr[3:0] == 4'h0;
			if (wr_ff)
				c_ff <= hwdata[17:0];
		end
	end
	AST_WALK_EDGE: assert property (en && ev == 8'h0C && um == 8'h03 && c_ff[16]
		|=> count_inc == $past(walk_start)) else $error("walk start count");
	AST_WALK_CYC: assert property (en && ev == 8'h0C && um == 8'h03 && !c_ff[16]
		|=> count_inc == $past(walk_busy)) else $error("walk cycle count");
	AST_FP_RET: assert property (en && ev == 8'h10 && um == 8'h81
		|=> count_inc == $past(fp_stack_ops_retired)) else $error("fp retire count");
	AST_MUL_EXE: assert property (en && ev == 8'h12 && um == 8'h01
		|=> count_inc == $past(multiply_executed)) else $error("mul exec count");
	AST_DIV_RET: assert property (en && ev == 8'h13 && um == 8'h81
		|=> count_inc == $past(divide_retired)) else $error("div retire count");
	AST_DIV_BUSY: assert property (en && ev == 8'h14 && um == 8'h01
		|=> count_inc == $past(divider_busy)) else $error("divider busy count");
	AST_L2_LOCAL: assert property (en && ev == 8'h21 && !um[7]
		|=> count_inc == $past(level2_addr_bus_cycles[0])) else $error("local core count");
	AST_L2_BOTH: assert property (en && ev == 8'h21 && um[7] |=> count_inc ==
		$past(level2_addr_bus_cycles[0]) + $past(level2_addr_bus_cycles[1])) else $error("both");
	AST_UNDEF: assert property (en && ev == 8'h12 && um == 8'h02
		|=> count_inc == 2'h0) else $error("undefined pair counted");
endmodule
`default_nettype wire

/* verification/pesd_src.sv */
// Purpose: Event sources of the core and cache side
// Assumes: One request bit becomes one source bit a cycle later
// Notes:   Sources launch on the clock edge, as pipeline flops would
`timescale 1ns/1ps
`default_nettype none
module pesd_src (
	input  wire logic        hclk,
	input  wire logic [34:0] req,
	output logic      [34:0] src
);
	always @(posedge hclk) begin
		src <= req;
	end
endmodule
`default_nettype wire

/* verification/pesd_decoder_tb.sv */
// Purpose: Self-checking bench for the event decoder
// Assumes: Zero-wait slave, running count readable at offset 8
// Notes:   Counts are read over the bus, so every case costs a few cycles
`timescale 1ns/1ps
`default_nettype none
module pesd_decoder_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [34:0] req = 35'h0;
	wire  [34:0] s;
	wire  [31:0] hrdata, count_value;
	wire  [1:0]  count_inc;
	wire         hreadyout, hresp;
	int          errors = 0, check_count = 0, cyc = 0;
	always #5 hclk = ~hclk;
	pesd_src i_src (.hclk(hclk), .req(req), .src(s));
	pesd_decoder i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .walk_start(s[0]),
		.walk_busy(s[1]), .fp_stack_ops_executed(s[2]), .fp_stack_ops_retired(s[3]),
		.fp_microcode_help(s[4]), .fp_microcode_help_retired(s[5]), .multiply_executed(s[6]),
		.multiply_retired(s[7]), .divide_executed(s[8]), .divide_retired(s[9]),
		.divider_busy(s[10]), .level2_addr_bus_cycles(s[12:11]),
		.level2_data_bus_cycles(s[14:13]), .level2_fills_demand(s[16:15]),
		.level2_fills_prefetch(s[18:17]), .level2_dirty_writebacks_in(s[20:19]),
		.level2_evict_demand(s[22:21]), .level2_evict_prefetch(s[24:23]),
		.level2_dirty_evict_demand(s[26:25]), .level2_dirty_evict_prefetch(s[28:27]),
		.level2_code_fetches(s[30:29]), .level2_code_state(s[34:31]),
		.count_inc(count_inc), .count_value(count_value));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= {28'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Clear and select, hold the sources five cycles, then read the count
	task automatic run(input logic [17:0] c, input logic [34:0] r, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b1, 4'h0, {13'h0, 1'b1, c}, d);
		req <= r;
		repeat (5) @(posedge hclk);
		req <= 35'h0;
		repeat (4) @(posedge hclk);
		bus(1'b0, 4'h8, 32'h0, d);
		chk(d, e);
		chk(count_value, e);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		bus(1'b0, 4'h0, 32'h0, d);
		chk(d, 32'h0);
		bus(1'b1, 4'h0, 32'h0007ABCD, d);
		bus(1'b0, 4'h0, 32'h0, d);
		chk(d, 32'h0003ABCD);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, 4'hC, 32'hFFFFFFFF, d);
		bus(1'b0, 4'hC, 32'h0, d);
		chk(d, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_page;
		logic [31:0] d;
		run(18'h3030C, 35'h1, 32'd5);
		bus(1'b0, 4'h4, 32'h0, d);
		chk(d, 32'h4);
		run(18'h3030C, 35'h2, 32'd0);
		run(18'h2030C, 35'h2, 32'd5);
		run(18'h2030C, 35'h1, 32'd0);
		$display("t_page done");
	endtask
	task automatic t_core;
		for (int i = 0; i < 4; i++) begin
			run({10'h201, 8'h10 + i[7:0]}, 35'h4 << 2 * i, 32'd5);
			run({10'h281, 8'h10 + i[7:0]}, 35'h8 << 2 * i, 32'd5);
			run({10'h281, 8'h10 + i[7:0]}, 35'h4 << 2 * i, 32'd0);
		end
		run(18'h20114, 35'h400, 32'd5);
		$display("t_core done");
	endtask
	// Sums of demand and prefetch stop at two per cycle
	task automatic t_l2;
		run(18'h20021, 35'h1800, 32'd5);
		run(18'h28021, 35'h1800, 32'd10);
		run(18'h28022, 35'h2000, 32'd5);
		run(18'h21024, 35'h28000, 32'd5);
		run(18'h20024, 35'h28000, 32'd10);
		run(18'h28024, 35'h78000, 32'd10);
		run(18'h20025, 35'h80000, 32'd5);
		run(18'h22026, 35'hA00000, 32'd5);
		run(18'h20027, 35'hA000000, 32'd10);
		run(18'h20428, 35'h220000000, 32'd5);
		run(18'h20128, 35'h220000000, 32'd0);
		$display("t_l2 done");
	endtask
	task automatic t_undef;
		logic [31:0] d;
		run(18'h20212, 35'h40, 32'd0);
		run(18'h00112, 35'h40, 32'd0);
		run(18'h20015, 35'h7FFFFFFFF, 32'd0);
		bus(1'b0, 4'h4, 32'h0, d);
		chk(d, 32'h0);
		$display("t_undef done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_page();
		t_core();
		t_l2();
		t_undef();
		summarize();
	end
endmodule
bind pesd_decoder pesd_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.walk_start(walk_start), .walk_busy(walk_busy),
	.fp_stack_ops_retired(fp_stack_ops_retired), .multiply_executed(multiply_executed),
	.divide_retired(divide_retired), .divider_busy(divider_busy),
	.level2_addr_bus_cycles(level2_addr_bus_cycles), .count_inc(count_inc));
`default_nettype wire
